//--- dv/pcf_crc_engine_checker.sv
// Concurrent checks on the register port and drain pulse of the CRC engine
`timescale 1ns/100ps

module pcf_crc_engine_checker
    import pcf_pkg::*;
(
    // Clock and reset
    input wire logic         REF_CLK,
    input wire logic         RST_N,
    // Watched ports
    input wire pcf_bus_req_t REG_REQ,
    input wire logic [15:0]  REG_RDATA,
    input wire logic         SLEEP_MODE,
    input wire logic         IDLE_MODE,
    input wire logic         DRAIN_IRQ
);
    // ----------------------------------------------------------------
    // Common clocking
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // Depth implied by the length field that a control read returns
    logic [4:0] depth_seen;
    assign depth_seen = (REG_RDATA[3:0] > PCF_PLEN_SMALL) ? PCF_DEPTH_SHORT : PCF_DEPTH_LONG;

    // Stop-in-idle as last written, so a frozen Idle can be told apart
    logic       sidl_seen;
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            sidl_seen <= 1'b0;
        else if (REG_REQ.wr && (REG_REQ.addr == PCF_ADDR_CTRL) && REG_REQ.be[1])
            sidl_seen <= REG_REQ.wdata[PCF_SIDL_BIT];
    end

    // Read of one register, answered in the next cycle
    sequence s_read(logic [2:0] a);
        REG_REQ.rd && (REG_REQ.addr == a);
    endsequence
    // Two frozen cycles, so no pop could land at the last edge
    sequence s_frozen;
        (SLEEP_MODE || (IDLE_MODE && sidl_seen)) [*2];
    endsequence

    a_rdata_read_slot: assert property ((REG_RDATA != 16'h0000) |-> $past(REG_REQ.rd))
        else $error("read data seen outside its slot");
    a_drain_one_cycle: assert property (DRAIN_IRQ |=> !DRAIN_IRQ)
        else $error("drain pulse longer than one cycle");
    a_ctrl_spare_zero: assert property (s_read(PCF_ADDR_CTRL) |=> REG_RDATA[15:14] == 2'h0 && !REG_RDATA[5])
        else $error("spare control bits read nonzero");
    a_tap_bit_zero: assert property (s_read(PCF_ADDR_TAPS) |=> !REG_RDATA[0])
        else $error("tap bit 0 read nonzero");
    a_full_flag_match: assert property (s_read(PCF_ADDR_CTRL) |=> REG_RDATA[7] == (REG_RDATA[12:8] == depth_seen))
        else $error("full flag disagrees with count");
    a_empty_flag_match: assert property (s_read(PCF_ADDR_CTRL) |=> REG_RDATA[6] == (REG_RDATA[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    a_count_in_depth: assert property (s_read(PCF_ADDR_CTRL) |=> REG_RDATA[12:8] <= depth_seen)
        else $error("count beyond fifo depth");
    a_sleep_no_drain: assert property (s_frozen |-> !DRAIN_IRQ)
        else $error("drain pulse while frozen");
endmodule : pcf_crc_engine_checker

bind pcf_crc_engine pcf_crc_engine_checker i_pcf_crc_engine_checker (
    .REF_CLK    (REF_CLK),
    .RST_N      (RST_N),
    .REG_REQ    (REG_REQ),
    .REG_RDATA  (REG_RDATA),
    .SLEEP_MODE (SLEEP_MODE),
    .IDLE_MODE  (IDLE_MODE),
    .DRAIN_IRQ  (DRAIN_IRQ)
);

//--- dv/pcf_crc_engine_tb.sv
// Self-checking bench for the programmable CRC engine with input FIFO
`timescale 1ns/100ps

module pcf_crc_engine_tb
    import pcf_pkg::*;
;
    logic         ref_clk;
    logic         rst_n;
    pcf_bus_req_t req;
    logic [15:0]  rdata;
    logic         sleep_mode;
    logic         idle_mode;
    logic         drain_irq;
    int           miscompares;
    int           n_compared;
    int           seed;
    int           irq_seen;

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    pcf_crc_engine i_pcf_crc_engine (
        .REF_CLK    (ref_clk),
        .RST_N      (rst_n),
        .REG_REQ    (req),
        .REG_RDATA  (rdata),
        .SLEEP_MODE (sleep_mode),
        .IDLE_MODE  (idle_mode),
        .DRAIN_IRQ  (drain_irq)
    );

    // Drain pulses counted on the edge, before the design updates them
    always @(posedge ref_clk)
        if (drain_irq === 1'b1)
            irq_seen++;

    // ----------------------------------------------------------------
    // Reporting and expectations
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk_cyc(input string name, input int exp, input int got);
        n_compared++;
        if (got != exp)
        begin
            miscompares++;
            $display("FAIL %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_cyc

    function automatic logic [15:0] mask(input int len);
        return 16'hffff >> (15 - len);
    endfunction : mask

    // Bit-serial reference, MSb first, top bit of the register as feedback
    function automatic logic [15:0] crc_fn(input logic [15:0] c, input logic [15:0] t,
                                           input int len, input logic [15:0] w);
        logic fb;
        for (int i = len; i >= 0; i--)
        begin
            fb = w[i] ^ c[len];
            for (int j = len; j > 0; j--)
                c[j] = c[j-1] ^ (t[j] & fb);
            c[0] = fb;
        end
        return c;
    endfunction : crc_fn

    function automatic logic [15:0] ctrl_val(input int cnt, input int len, input bit go,
                                             input bit sidl);
        int dep;
        dep = (len > 7) ? 8 : 16;
        return {2'b00, sidl, cnt[4:0], cnt == dep, cnt == 0, 1'b0, go, len[3:0]};
    endfunction : ctrl_val

    // ----------------------------------------------------------------
    // Register port; one idle cycle between requests keeps drives apart
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req <= '0;
    endtask : wr

    task automatic rchk(input string name, input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 16'h0000, be: 2'b00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req <= '0;
        #1 chk(name, exp, rdata);
    endtask : rchk

    // Long words go in as two byte writes; only the top byte queues them
    task automatic push(input int len, input logic [15:0] d);
        if (len > 7)
            wr(PCF_ADDR_INPUT, d, 2'b01);
        wr(PCF_ADDR_INPUT, d, (len > 7) ? 2'b10 : 2'b01);
    endtask : push

    task automatic wait_irq(output int k);
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
            #1;
        end while (drain_irq !== 1'b1 && k < 600);
        if (drain_irq !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
    endtask : wait_irq

    // Load taps, seed and length, queue n random words, track the result
    task automatic load(input int len, input int n, output logic [15:0] crc);
        logic [15:0] taps;
        logic [15:0] d;
        taps = 16'($random(seed)) & 16'hfffe;
        crc = 16'($random(seed)) & mask(len);
        wr(PCF_ADDR_TAPS, taps, 2'b11);
        wr(PCF_ADDR_RESULT, crc, 2'b11);
        wr(PCF_ADDR_CTRL, 16'(len), 2'b11);
        for (int i = 0; i < n; i++)
        begin
            d = 16'($random(seed)) & mask(len);
            push(len, d);
            crc = crc_fn(crc, taps, len, d);
        end
    endtask : load

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [15:0] crc;
        int          len;
        int          n;
        int          k;
        miscompares = 0;
        n_compared = 0;
        irq_seen = 0;
        seed = 27;
        rst_n = 1'b0;
        req = '0;
        sleep_mode = 1'b0;
        idle_mode = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk("ctrl_rst", PCF_ADDR_CTRL, 16'h0040);
        rchk("taps_rst", PCF_ADDR_TAPS, 16'h0000);
        rchk("result_rst", PCF_ADDR_RESULT, 16'h0000);
        wr(PCF_ADDR_CTRL, 16'hffff, 2'b11);
        rchk("ctrl_ro", PCF_ADDR_CTRL, ctrl_val(0, 15, 1, 1));
        wr(PCF_ADDR_TAPS, 16'hffff, 2'b11);
        rchk("taps_rw", PCF_ADDR_TAPS, 16'hfffe);
        wr(3'h5, 16'h1234, 2'b11);
        rchk("unmapped", 3'h5, 16'h0000);
        // Random polynomials, lengths and word counts, both byte lanes
        for (int t = 0; t < 10; t++)
        begin
            len = (t == 0) ? 7 : (t == 1) ? 15 : (t == 2) ? 0 : ($random(seed) & 15);
            n = 1 + ($random(seed) & 3);
            load(len, n, crc);
            rchk("queued", PCF_ADDR_CTRL, ctrl_val(n, len, 0, 0));
            wr(PCF_ADDR_CTRL, 16'h0010 | 16'(len), 2'b11);
            wait_irq(k);
            chk_cyc("shift_cycles", (len + 1) * n, k);
            rchk("drained", PCF_ADDR_CTRL, ctrl_val(0, len, 1, 0));
            rchk("crc", PCF_ADDR_RESULT, crc);
        end
        // Fill to each depth, then one word more rolls the count over
        for (int m = 0; m < 2; m++)
        begin
            len = 7 + m;
            wr(PCF_ADDR_CTRL, 16'(len), 2'b11);
            for (int i = 0; i < 16 - 8 * m; i++)
                push(len, 16'h00ff);
            rchk("full", PCF_ADDR_CTRL, ctrl_val(16 - 8 * m, len, 0, 0));
            k = irq_seen;
            push(len, 16'h00ff);
            rchk("rollover", PCF_ADDR_CTRL, ctrl_val(0, len, 0, 0));
            chk_cyc("no_drain", k, irq_seen);
            if (m == 1)
                rchk("staged", PCF_ADDR_INPUT, 16'h00ff);
        end
        // Sleep, idle with stop bit, idle without: freeze or keep running
        for (int m = 0; m < 3; m++)
        begin
            load(7, 2, crc);
            sleep_mode <= (m == 0);
            idle_mode <= (m != 0);
            wr(PCF_ADDR_CTRL, (m == 1) ? 16'h2017 : 16'h0017, 2'b11);
            if (m < 2)
                push(7, 16'h005a);
            repeat (40) @(posedge ref_clk);
            rchk("frozen", PCF_ADDR_CTRL, ctrl_val((m == 2) ? 0 : 2, 7, 1, m == 1));
            @(posedge ref_clk);
            sleep_mode <= 1'b0;
            idle_mode <= 1'b0;
            if (m < 2)
                wait_irq(k);
            rchk("resumed_crc", PCF_ADDR_RESULT, crc);
        end
        print_verdict();
    end
endmodule : pcf_crc_engine_tb

//--- logic/pcf_crc_engine.sv
// Programmable CRC shifter with byte-writable input FIFO and register port
//
// Operation
// R1: Taps 15..1 and 4-bit length are programmable
// R2: x^0 always applied, top term implicit
// R3: Length field is polynomial length minus one
// R4: FIFO depth 8 above length 7, else 16
// R5: Input FIFO accepts single byte writes
// R6: Count increments when MSb byte is written
// R7: Shift only while go set and count nonzero
// R8: Count decrements as each word finishes shifting
// R9: One bit per clock, length+1 cycles per word
// R10: Full at depth, empty at zero count
// R11: Write while full rolls count to zero
// R12: Interrupt exactly on count change one to zero
// R13: Software waits a cycle before reading count
// R14: Software waits for empty before reading result
// R15: Software flushes FIFO by running shifter until empty
// R16: Software primes FIFO, then feeds while below depth
// R17: Sleep freezes shifter, FIFO and count
// R18: Stop-in-idle bit freezes in Idle too
// R19: Count readable, read-only, in control bits 12:8
// R20: Control bit 4 runs or stops shifter
// R21: Tap bits 15:1 enable feedback, bit 0 reads zero
// R22: MSb-first LFSR, input xor top bit feeds taps
// R23: Result register reads CRC and accepts a seed
`timescale 1ns/100ps

module pcf_crc_engine
    import pcf_pkg::*;
(
    // Clock and reset
    input  wire logic         REF_CLK,
    input  wire logic         RST_N,
    // Register port
    input  wire pcf_bus_req_t REG_REQ,
    output logic [15:0]       REG_RDATA,
    // Power save state from the clock controller
    input  wire logic         SLEEP_MODE,
    input  wire logic         IDLE_MODE,
    // Drain event
    output logic              DRAIN_IRQ
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        stop_in_idle_reg;
    logic        shifter_go_reg;
    logic [3:0]  poly_len_minus_one_reg;
    logic [15:0] crc_tap_enables_reg;
    logic [15:0] crc_result_word_reg;
    logic [15:0] crc_input_word_reg;
    logic [15:0] fifo_mem [PCF_MEM_DEPTH];
    logic [3:0]  wr_ptr_reg;
    logic [3:0]  rd_ptr_reg;
    logic [3:0]  bit_cnt_reg;
    logic [4:0]  valid_word_count_reg;
    logic        irq_reg;
    logic [15:0] rdata_reg;

    // ------------------------------------------------------------------
    // Combinational terms
    // ------------------------------------------------------------------
    logic        freeze;
    logic [4:0]  fifo_depth;
    logic [3:0]  ptr_last;
    logic        fifo_full_flag;
    logic        fifo_empty_flag;
    logic        input_wr;
    logic        msb_in_high_byte;
    logic        word_written;
    logic        push;
    logic        overflow;
    logic        shift_en;
    logic        pop;
    logic [15:0] merged_word;
    logic [15:0] cur_word;
    logic [3:0]  bit_pos;
    logic        in_bit;
    logic        feedback;
    logic [15:0] crc_next;
    logic [15:0] ctrl_view;

    // Idle only stops the block when software asked for it
    assign freeze = SLEEP_MODE | (IDLE_MODE & stop_in_idle_reg); // R17 R18

    // Depth follows the length field; a change mid-stream is not re-packed
    assign fifo_depth = (poly_len_minus_one_reg > PCF_PLEN_SMALL)
                      ? PCF_DEPTH_SHORT : PCF_DEPTH_LONG;        // R4
    assign ptr_last   = 4'(fifo_depth - 5'h01);

    // Flags are decoded from the count, so they can never disagree with it
    assign fifo_full_flag  = (valid_word_count_reg == fifo_depth); // R10
    assign fifo_empty_flag = (valid_word_count_reg == 5'h00);      // R10

    // ------------------------------------------------------------------
    // Input word assembly
    // ------------------------------------------------------------------
    // A word is complete once the byte holding its MSb arrives
    assign input_wr         = REG_REQ.wr && (REG_REQ.addr == PCF_ADDR_INPUT);
    assign msb_in_high_byte = (poly_len_minus_one_reg > PCF_PLEN_SMALL);  // R3
    assign word_written     = input_wr
                            && (msb_in_high_byte ? REG_REQ.be[1] : REG_REQ.be[0]); // R5 R6
    assign push             = word_written && !freeze;                    // R17
    assign overflow         = push && fifo_full_flag;                     // R11

    // Byte lanes not written keep the staged value of an earlier write
    assign merged_word = {REG_REQ.be[1] ? REG_REQ.wdata[15:8] : crc_input_word_reg[15:8],
                          REG_REQ.be[0] ? REG_REQ.wdata[7:0]  : crc_input_word_reg[7:0]};

    // ------------------------------------------------------------------
    // Serial shifter control
    // ------------------------------------------------------------------
    assign shift_en = shifter_go_reg && !fifo_empty_flag && !freeze; // R7 R20 R17
    assign cur_word = fifo_mem[rd_ptr_reg];
    assign bit_pos  = poly_len_minus_one_reg - bit_cnt_reg;          // R22
    assign in_bit   = cur_word[bit_pos];
    // Last bit of the word leaves the FIFO after length+1 shifts
    assign pop      = shift_en && (bit_cnt_reg == poly_len_minus_one_reg); // R8 R9

    // Feedback from the top bit of the active length; the top term is implicit
    assign feedback = in_bit ^ crc_result_word_reg[poly_len_minus_one_reg]; // R2 R22

    // ------------------------------------------------------------------
    // LFSR next state, one slice per bit
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < PCF_DW; i++)
        begin : g_lfsr
            if (i == 0)
            begin : g_x0
                // Constant term always closes the loop
                assign crc_next[i] = feedback; // R2
            end
            else
            begin : g_xn
                // Bits above the active length are held at zero
                assign crc_next[i] = (4'(i) <= poly_len_minus_one_reg)
                    ? (crc_result_word_reg[i-1] ^ (crc_tap_enables_reg[i] & feedback))
                    : 1'b0; // R1 R21 R22
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Byte lanes gate the writable fields; count and flags are not writable
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            stop_in_idle_reg       <= 1'b0;
            shifter_go_reg         <= 1'b0;
            poly_len_minus_one_reg <= PCF_PLEN_RST;
        end
        else if (REG_REQ.wr && (REG_REQ.addr == PCF_ADDR_CTRL))
        begin
            if (REG_REQ.be[1])
                stop_in_idle_reg <= REG_REQ.wdata[PCF_SIDL_BIT]; // R18
            if (REG_REQ.be[0])
            begin
                shifter_go_reg         <= REG_REQ.wdata[PCF_GO_BIT];                // R20
                poly_len_minus_one_reg <= REG_REQ.wdata[PCF_PLEN_MSB:PCF_PLEN_LSB]; // R1 R3
            end
        end
    end

    // ------------------------------------------------------------------
    // Tap enable register
    // ------------------------------------------------------------------
    // Bit 0 has no storage; x^0 is wired into the shifter
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            crc_tap_enables_reg <= PCF_TAPS_RST;
        else if (REG_REQ.wr && (REG_REQ.addr == PCF_ADDR_TAPS))
        begin
            if (REG_REQ.be[1])
                crc_tap_enables_reg[15:8] <= REG_REQ.wdata[15:8]; // R1 R21
            if (REG_REQ.be[0])
                crc_tap_enables_reg[7:0]  <= REG_REQ.wdata[7:0] & PCF_TAPS_WMASK[7:0]; // R21
        end
    end

    // ------------------------------------------------------------------
    // CRC result register
    // ------------------------------------------------------------------
    // A software seed wins over a shift in the same cycle
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            crc_result_word_reg <= PCF_RESULT_RST;
        else if (REG_REQ.wr && (REG_REQ.addr == PCF_ADDR_RESULT))
        begin
            if (REG_REQ.be[1])
                crc_result_word_reg[15:8] <= REG_REQ.wdata[15:8]; // R23
            if (REG_REQ.be[0])
                crc_result_word_reg[7:0]  <= REG_REQ.wdata[7:0];  // R23
        end
        else if (shift_en)
            crc_result_word_reg <= crc_next; // R9 R22
    end

    // ------------------------------------------------------------------
    // Input staging word
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            crc_input_word_reg <= PCF_WORD_RST;
        else if (input_wr && !freeze)
            crc_input_word_reg <= merged_word; // R5
    end

    // ------------------------------------------------------------------
    // FIFO storage
    // ------------------------------------------------------------------
    // No reset on the array; only slots below the count are ever read
    always_ff @(posedge REF_CLK)
    begin
        if (push && !overflow)
            fifo_mem[wr_ptr_reg] <= merged_word;
    end

    // ------------------------------------------------------------------
    // FIFO pointers and bit counter
    // ------------------------------------------------------------------
    // Overflow drops the word and restarts as an empty FIFO
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            wr_ptr_reg  <= 4'h0;
            rd_ptr_reg  <= 4'h0;
            bit_cnt_reg <= 4'h0;
        end
        else if (overflow)
        begin
            wr_ptr_reg  <= 4'h0; // R11
            rd_ptr_reg  <= 4'h0; // R11
            bit_cnt_reg <= 4'h0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg >= ptr_last) ? 4'h0 : 4'(wr_ptr_reg + 4'h1); // R4
            if (pop)
            begin
                rd_ptr_reg  <= (rd_ptr_reg >= ptr_last) ? 4'h0 : 4'(rd_ptr_reg + 4'h1); // R8
                bit_cnt_reg <= 4'h0;
            end
            else if (shift_en)
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1); // R9
        end
    end

    // ------------------------------------------------------------------
    // Valid word count
    // ------------------------------------------------------------------
    // Push and pop in one cycle cancel out unless the push overflows a full FIFO, which clears the count
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            valid_word_count_reg <= 5'h00;
        else if (overflow)
            valid_word_count_reg <= 5'h00; // R11
        else if (push && !pop)
            valid_word_count_reg <= 5'(valid_word_count_reg + 5'h01); // R6
        else if (pop && !push)
            valid_word_count_reg <= 5'(valid_word_count_reg - 5'h01); // R8
    end

    // ------------------------------------------------------------------
    // Drain event
    // ------------------------------------------------------------------
    // Only a shift-out takes the count from 1 to 0; an overflow never does
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            irq_reg <= 1'b0;
        else
            irq_reg <= pop && !push && (valid_word_count_reg == 5'h01); // R12
    end

    assign DRAIN_IRQ = irq_reg;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb
    begin
        ctrl_view                               = 16'h0000;
        ctrl_view[PCF_SIDL_BIT]                 = stop_in_idle_reg;
        ctrl_view[PCF_CNT_MSB:PCF_CNT_LSB]      = valid_word_count_reg; // R19
        ctrl_view[PCF_FULL_BIT]                 = fifo_full_flag;       // R10
        ctrl_view[PCF_EMPTY_BIT]                = fifo_empty_flag;      // R10
        ctrl_view[PCF_GO_BIT]                   = shifter_go_reg;
        ctrl_view[PCF_PLEN_MSB:PCF_PLEN_LSB]    = poly_len_minus_one_reg;
    end

    // Data appear in the cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            rdata_reg <= 16'h0000;
        else if (REG_REQ.rd)
        begin
            if (REG_REQ.addr == PCF_ADDR_CTRL)
                rdata_reg <= ctrl_view;
            else if (REG_REQ.addr == PCF_ADDR_TAPS)
                rdata_reg <= crc_tap_enables_reg & PCF_TAPS_WMASK; // R21
            else if (REG_REQ.addr == PCF_ADDR_RESULT)
                rdata_reg <= crc_result_word_reg; // R23
            else if (REG_REQ.addr == PCF_ADDR_INPUT)
                rdata_reg <= crc_input_word_reg;
            else
                rdata_reg <= 16'h0000;
        end
        else
            rdata_reg <= 16'h0000;
    end

    assign REG_RDATA = rdata_reg;

endmodule : pcf_crc_engine

//--- logic/pcf_pkg.sv
// Shared constants and types for the programmable CRC engine with input FIFO
package pcf_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int          PCF_AW           = 3;
    localparam int          PCF_DW           = 16;

    // Register indexes on the plain register port
    localparam logic [2:0]  PCF_ADDR_CTRL    = 3'h0;
    localparam logic [2:0]  PCF_ADDR_TAPS    = 3'h1;
    localparam logic [2:0]  PCF_ADDR_RESULT  = 3'h2;
    localparam logic [2:0]  PCF_ADDR_INPUT   = 3'h3;

    // ------------------------------------------------------------------
    // crc_control field positions
    // ------------------------------------------------------------------
    localparam int          PCF_SIDL_BIT     = 13;
    localparam int          PCF_CNT_MSB      = 12;
    localparam int          PCF_CNT_LSB      = 8;
    localparam int          PCF_FULL_BIT     = 7;
    localparam int          PCF_EMPTY_BIT    = 6;
    localparam int          PCF_GO_BIT       = 4;
    localparam int          PCF_PLEN_MSB     = 3;
    localparam int          PCF_PLEN_LSB     = 0;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [3:0]  PCF_PLEN_RST     = 4'h0;
    localparam logic [15:0] PCF_TAPS_RST     = 16'h0000;
    localparam logic [15:0] PCF_TAPS_WMASK   = 16'hfffe;
    localparam logic [15:0] PCF_RESULT_RST   = 16'h0000;
    localparam logic [15:0] PCF_WORD_RST     = 16'h0000;

    // ------------------------------------------------------------------
    // FIFO sizing
    // ------------------------------------------------------------------
    localparam int          PCF_MEM_DEPTH    = 16;
    localparam logic [3:0]  PCF_PLEN_SMALL   = 4'h7;
    localparam logic [4:0]  PCF_DEPTH_SHORT  = 5'h08;
    localparam logic [4:0]  PCF_DEPTH_LONG   = 5'h10;

    // One register port request, all fields valid in the same cycle
    typedef struct packed {
        logic [PCF_AW-1:0] addr;
        logic [PCF_DW-1:0] wdata;
        logic [1:0]        be;
        logic              wr;
        logic              rd;
    } pcf_bus_req_t;

endpackage : pcf_pkg
